// ---- hdl/csmx_pkg.sv ----
/*
 Constants, field positions, register offsets and the operation type
 shared by the execute core and its helpers.
 Assumes instructions numbered with bit 0 as the most significant bit.
*/
package csmx_pkg;
	localparam int          XLEN          = 32;
	localparam int          HALF_W        = 16;
	localparam int          REG_IDX_W     = 5;
	localparam int          SPLIT_HALF    = 5;
	localparam int          SPLIT_W       = 10;
	// Instruction field lsb positions (bit 0 big-endian is instr[31])
	localparam int          F_PO_LSB      = 26;
	localparam int          F_RD_LSB      = 21;
	localparam int          F_RA_LSB      = 16;
	localparam int          F_RB_LSB      = 11;
	localparam int          F_OE          = 10;
	localparam int          F_XO_LSB      = 1;
	localparam int          F_RC          = 0;
	localparam int          F_DEST_COND_FIELD_LSB    = 23;
	localparam int          F_SRC_COND_FIELD_LSB    = 18;
	localparam int          F_SPLIT_LSB   = 11;
	localparam int          F_PRIV_BIT    = 20;
	localparam logic [5:0]  PO_MAC        = 6'h04;
	localparam logic [5:0]  PO_CRF        = 6'h13;
	localparam logic [5:0]  PO_EXT        = 6'h1F;
	localparam logic [8:0]  XO_MAC_LU     = 9'h18C;
	localparam logic [9:0]  XO_COPY_CR    = 10'h000;
	localparam logic [9:0]  XO_EXC_TO_CR  = 10'h200;
	localparam logic [9:0]  XO_RD_CR      = 10'h013;
	localparam logic [9:0]  XO_RD_DCR     = 10'h143;
	localparam logic [9:0]  XO_RD_MSR     = 10'h053;
	localparam logic [9:0]  XO_RD_SPR     = 10'h153;
	// Condition and exception register layout
	localparam int          CR_FIELD_W    = 4;
	localparam int          CR_TOP_LSB    = 28;
	localparam int          XER_SO        = 31;
	localparam int          XER_OV        = 30;
	localparam int          XER_TOP_LSB   = 28;
	localparam int          MSR_PR        = 14;
	localparam int          DCR_IDX_W     = 2;
	localparam int          SPR_IDX_W     = 3;
	// APB map
	localparam int          AW            = 12;
	localparam int          WORD_LSB      = 2;
	localparam int          GPR_SPAN_LSB  = 7;
	localparam int          DCR_SPAN_LSB  = 4;
	localparam int          SPR_SPAN_LSB  = 5;
	localparam logic [11:0] OFS_CTRL      = 12'h000;
	localparam logic [11:0] OFS_COND      = 12'h004;
	localparam logic [11:0] OFS_FXEXC     = 12'h008;
	localparam logic [11:0] OFS_MSTATE    = 12'h00C;
	localparam logic [11:0] OFS_IRQ_STAT  = 12'h010;
	localparam logic [11:0] OFS_IRQ_EN    = 12'h014;
	localparam logic [11:0] OFS_IRQ_CLR   = 12'h018;
	localparam logic [11:0] OFS_RETIRED   = 12'h01C;
	localparam logic [11:0] OFS_GPR_BASE  = 12'h100;
	localparam logic [11:0] OFS_DCR_BASE  = 12'h200;
	localparam logic [11:0] OFS_SPR_BASE  = 12'h300;
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;
	localparam logic [31:0] RST_MSTATE    = 32'h0000_0000;
	localparam int          CTRL_EN       = 0;
	// Interrupt status layout
	localparam int          IRQ_W         = 4;
	localparam int          IRQ_RETIRE    = 0;
	localparam int          IRQ_PROG      = 1;
	localparam int          IRQ_OVF       = 2;
	localparam int          IRQ_UNCLAIM   = 3;
	typedef enum logic [2:0] {
		OPK_NONE, OPK_MAC, OPK_COPY_CR, OPK_EXC_TO_CR,
		OPK_RD_CR, OPK_RD_DCR, OPK_RD_MSR, OPK_RD_SPR
	} csmx_op_t;
endpackage

// ---- hdl/csmx_split_swap.sv ----
/*
 Swaps the two halves of a split register-number field.
 Assumes the field arrives with its big-endian bit 0 in the msb.
*/
`timescale 1ns/1ps
module csmx_split_swap #(
	parameter int HALF = 5
) (
	input  wire logic [2*HALF-1:0] split_field,
	output wire logic [2*HALF-1:0] reg_num
);
	// Upper five bits of the number sit in the field's lower half
	assign reg_num = {split_field[HALF-1:0], split_field[2*HALF-1:HALF]};
endmodule

// ---- hdl/csmx_mac.sv ----
/*
 Unsigned low-halfword multiply-accumulate, modulo, with field 0 flags.
 Assumes operands are read from the register file in the same cycle.
*/
`timescale 1ns/1ps
module csmx_mac (
	input  wire logic [31:0] first_src,
	input  wire logic [31:0] second_src,
	input  wire logic [31:0] dest_src,
	input  wire logic        so_in,
	output wire logic [31:0] result,
	output wire logic        carry,
	output wire logic [3:0]  field0_flags
);
	logic [31:0] prod;
	logic [32:0] sum;

	assign prod         = first_src[csmx_pkg::HALF_W-1:0] * second_src[csmx_pkg::HALF_W-1:0];
	assign sum          = {1'b0, prod} + {1'b0, dest_src};
	// Carry dropped, no saturation
	assign result       = sum[31:0];
	assign carry        = sum[32];
	assign field0_flags = {result[31], ~result[31] & (|result), ~(|result), so_in};
endmodule

// ---- hdl/csmx_core.sv ----
/*
 Execute core for the multiply-accumulate, condition-field moves and
 register reads, with its register file and an APB slave for software.
 Assumes one instruction per issue handshake and an APB master on pclk.
*/
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module csmx_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        issue_valid,
	input  wire logic [31:0] issue_instr,
	output logic             issue_ready,
	output logic             retire_valid,
	output logic             retire_prog_exc,
	output logic             retire_unclaimed,
	output logic             irq
);
	localparam int NGPR = 1 << csmx_pkg::REG_IDX_W;
	localparam int NDCR = 1 << csmx_pkg::DCR_IDX_W;
	localparam int NSPR = 1 << csmx_pkg::SPR_IDX_W;
	localparam int AW_TOP   = csmx_pkg::AW - 1;
	localparam int XLEN_PAD = csmx_pkg::XLEN - csmx_pkg::IRQ_W;

	logic [31:0]                 gpr_mem [NGPR];
	logic [31:0]                 dcr_mem [NDCR];
	logic [31:0]                 spr_mem [NSPR];
	logic [31:0]                 ctrl_reg;
	logic [31:0]                 cond_flags_reg;
	logic [31:0]                 cond_flags_next;
	logic [31:0]                 fixed_point_exc_reg;
	logic [31:0]                 machine_state_reg;
	logic [31:0]                 retired_reg;
	logic [csmx_pkg::IRQ_W-1:0]  irq_stat_reg;
	logic [csmx_pkg::IRQ_W-1:0]  irq_en_reg;
	logic [csmx_pkg::IRQ_W-1:0]  irq_set;
	csmx_pkg::csmx_op_t          op;
	logic [4:0]                  rd_idx;
	logic [4:0]                  ra_idx;
	logic [4:0]                  rb_idx;
	logic [2:0]                  dest_cond_field;
	logic [2:0]                  src_cond_field;
	logic                        ovf_en;
	logic                        record_flag;
	logic [9:0]                  dev_ctl_num;
	logic [9:0]                  special_num;
	logic                        take;
	logic                        user_mode;
	logic                        fault;
	logic                        commit;
	logic [31:0]                 mac_result;
	logic                        mac_carry;
	logic [3:0]                  mac_flags;
	logic                        so_now;
	logic [31:0]                 dcr_rd;
	logic [31:0]                 spr_rd;
	logic                        gpr_we;
	logic [31:0]                 gpr_wdata;
	logic                        apb_wr;
	logic [31:0]                 rd_data;
	logic                        rd_err;
	logic                        hit_gpr;
	logic                        hit_dcr;
	logic                        hit_spr;

	function automatic int cr_lsb(input logic [2:0] n);
		return csmx_pkg::CR_TOP_LSB - csmx_pkg::CR_FIELD_W * int'(n);
	endfunction

	// Field extraction with bit 0 as the msb of the word
	assign rd_idx          = issue_instr[csmx_pkg::F_RD_LSB +: csmx_pkg::REG_IDX_W];
	assign ra_idx          = issue_instr[csmx_pkg::F_RA_LSB +: csmx_pkg::REG_IDX_W];
	assign rb_idx          = issue_instr[csmx_pkg::F_RB_LSB +: csmx_pkg::REG_IDX_W];
	assign dest_cond_field = issue_instr[csmx_pkg::F_DEST_COND_FIELD_LSB +: 3];
	assign src_cond_field  = issue_instr[csmx_pkg::F_SRC_COND_FIELD_LSB +: 3];
	assign ovf_en          = issue_instr[csmx_pkg::F_OE];
	assign record_flag     = issue_instr[csmx_pkg::F_RC];

	// Reserved bits are not checked, so they cannot fault
	always_comb begin
		op = csmx_pkg::OPK_NONE;
		unique case (issue_instr[csmx_pkg::F_PO_LSB +: 6])
			csmx_pkg::PO_MAC: begin
				if (issue_instr[csmx_pkg::F_XO_LSB +: 9] == csmx_pkg::XO_MAC_LU)
					op = csmx_pkg::OPK_MAC;
			end
			csmx_pkg::PO_CRF: begin
				if (issue_instr[csmx_pkg::F_XO_LSB +: 10] == csmx_pkg::XO_COPY_CR)
					op = csmx_pkg::OPK_COPY_CR;
			end
			csmx_pkg::PO_EXT: begin
				unique case (issue_instr[csmx_pkg::F_XO_LSB +: 10])
					csmx_pkg::XO_EXC_TO_CR: op = csmx_pkg::OPK_EXC_TO_CR;
					csmx_pkg::XO_RD_CR:     op = csmx_pkg::OPK_RD_CR;
					csmx_pkg::XO_RD_DCR:    op = csmx_pkg::OPK_RD_DCR;
					csmx_pkg::XO_RD_MSR:    op = csmx_pkg::OPK_RD_MSR;
					csmx_pkg::XO_RD_SPR:    op = csmx_pkg::OPK_RD_SPR;
					default:                op = csmx_pkg::OPK_NONE;
				endcase
			end
			default: op = csmx_pkg::OPK_NONE;
		endcase
	end

	csmx_split_swap #(.HALF(csmx_pkg::SPLIT_HALF)) u_dcr_swap (
		.split_field (issue_instr[csmx_pkg::F_SPLIT_LSB +: csmx_pkg::SPLIT_W]),
		.reg_num     (dev_ctl_num)
	);
	csmx_split_swap #(.HALF(csmx_pkg::SPLIT_HALF)) u_spr_swap (
		.split_field (issue_instr[csmx_pkg::F_SPLIT_LSB +: csmx_pkg::SPLIT_W]),
		.reg_num     (special_num)
	);

	// Sticky copy seen by field 0 already includes this overflow
	assign so_now = fixed_point_exc_reg[csmx_pkg::XER_SO] | (ovf_en & mac_carry);
	csmx_mac u_mac (
		.first_src    (gpr_mem[ra_idx]),
		.second_src   (gpr_mem[rb_idx]),
		.dest_src     (gpr_mem[rd_idx]),
		.so_in        (ovf_en ? so_now : fixed_point_exc_reg[csmx_pkg::XER_SO]),
		.result       (mac_result),
		.carry        (mac_carry),
		.field0_flags (mac_flags)
	);

	assign take      = issue_valid & issue_ready;
	assign user_mode = machine_state_reg[csmx_pkg::MSR_PR];
	always_comb begin
		fault = 1'b0;
		if ((op == csmx_pkg::OPK_RD_DCR || op == csmx_pkg::OPK_RD_MSR) && user_mode)
			fault = 1'b1;
		if (op == csmx_pkg::OPK_RD_SPR && user_mode && issue_instr[csmx_pkg::F_PRIV_BIT])
			fault = 1'b1;
	end
	assign commit = take & ~fault & (op != csmx_pkg::OPK_NONE);

	// Numbers outside the implemented set read as zero
	assign dcr_rd = (dev_ctl_num[9:csmx_pkg::DCR_IDX_W] == '0) ?
		dcr_mem[dev_ctl_num[csmx_pkg::DCR_IDX_W-1:0]] : csmx_pkg::RST_WORD;
	assign spr_rd = (special_num[9:csmx_pkg::SPR_IDX_W] == '0) ?
		spr_mem[special_num[csmx_pkg::SPR_IDX_W-1:0]] : csmx_pkg::RST_WORD;

	always_comb begin
		gpr_we    = commit;
		gpr_wdata = mac_result;
		unique case (op)
			csmx_pkg::OPK_RD_CR:  gpr_wdata = cond_flags_reg;
			csmx_pkg::OPK_RD_DCR: gpr_wdata = dcr_rd;
			csmx_pkg::OPK_RD_MSR: gpr_wdata = machine_state_reg;
			csmx_pkg::OPK_RD_SPR: gpr_wdata = spr_rd;
			csmx_pkg::OPK_COPY_CR, csmx_pkg::OPK_EXC_TO_CR, csmx_pkg::OPK_NONE: gpr_we = 1'b0;
			csmx_pkg::OPK_MAC:    gpr_wdata = mac_result;
		endcase
	end

	always_comb begin
		cond_flags_next = cond_flags_reg;
		if (op == csmx_pkg::OPK_MAC && record_flag)
			cond_flags_next[csmx_pkg::CR_TOP_LSB +: csmx_pkg::CR_FIELD_W] = mac_flags;
		if (op == csmx_pkg::OPK_COPY_CR)
			cond_flags_next[cr_lsb(dest_cond_field) +: csmx_pkg::CR_FIELD_W] =
				cond_flags_reg[cr_lsb(src_cond_field) +: csmx_pkg::CR_FIELD_W];
		if (op == csmx_pkg::OPK_EXC_TO_CR)
			cond_flags_next[cr_lsb(dest_cond_field) +: csmx_pkg::CR_FIELD_W] =
				fixed_point_exc_reg[csmx_pkg::XER_TOP_LSB +: csmx_pkg::CR_FIELD_W];
	end

	// APB: one wait state so read data and pready come from flops
	assign apb_wr  = psel & penable & pready & pwrite;
	assign hit_gpr = paddr[AW_TOP:csmx_pkg::GPR_SPAN_LSB] ==
		csmx_pkg::OFS_GPR_BASE[AW_TOP:csmx_pkg::GPR_SPAN_LSB];
	assign hit_dcr = paddr[AW_TOP:csmx_pkg::DCR_SPAN_LSB] ==
		csmx_pkg::OFS_DCR_BASE[AW_TOP:csmx_pkg::DCR_SPAN_LSB];
	assign hit_spr = paddr[AW_TOP:csmx_pkg::SPR_SPAN_LSB] ==
		csmx_pkg::OFS_SPR_BASE[AW_TOP:csmx_pkg::SPR_SPAN_LSB];

	always_comb begin
		rd_data = csmx_pkg::RST_WORD;
		rd_err  = 1'b0;
		if (paddr[csmx_pkg::WORD_LSB-1:0] != '0)
			rd_err = 1'b1;
		else if (hit_gpr)
			rd_data = gpr_mem[paddr[csmx_pkg::WORD_LSB +: csmx_pkg::REG_IDX_W]];
		else if (hit_dcr)
			rd_data = dcr_mem[paddr[csmx_pkg::WORD_LSB +: csmx_pkg::DCR_IDX_W]];
		else if (hit_spr)
			rd_data = spr_mem[paddr[csmx_pkg::WORD_LSB +: csmx_pkg::SPR_IDX_W]];
		else begin
			unique case (paddr)
				csmx_pkg::OFS_CTRL:     rd_data = ctrl_reg;
				csmx_pkg::OFS_COND:     rd_data = cond_flags_reg;
				csmx_pkg::OFS_FXEXC:    rd_data = fixed_point_exc_reg;
				csmx_pkg::OFS_MSTATE:   rd_data = machine_state_reg;
				csmx_pkg::OFS_IRQ_STAT: rd_data = {{(XLEN_PAD){1'b0}}, irq_stat_reg};
				csmx_pkg::OFS_IRQ_EN:   rd_data = {{(XLEN_PAD){1'b0}}, irq_en_reg};
				csmx_pkg::OFS_IRQ_CLR:  rd_data = csmx_pkg::RST_WORD;
				csmx_pkg::OFS_RETIRED:  rd_data = retired_reg;
				default:                rd_err  = 1'b1;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= csmx_pkg::RST_WORD;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= rd_err;
			prdata  <= pwrite ? csmx_pkg::RST_WORD : rd_data;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Register file has no reset; an instruction write beats software
	always_ff @(posedge pclk) begin
		if (gpr_we)
			gpr_mem[rd_idx] <= gpr_wdata;
		else if (apb_wr && !pslverr && hit_gpr)
			gpr_mem[paddr[csmx_pkg::WORD_LSB +: csmx_pkg::REG_IDX_W]] <= pwdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NDCR; i++)
				dcr_mem[i] <= csmx_pkg::RST_WORD;
			for (int i = 0; i < NSPR; i++)
				spr_mem[i] <= csmx_pkg::RST_WORD;
		end else if (apb_wr && !pslverr) begin
			if (hit_dcr)
				dcr_mem[paddr[csmx_pkg::WORD_LSB +: csmx_pkg::DCR_IDX_W]] <= pwdata;
			if (hit_spr)
				spr_mem[paddr[csmx_pkg::WORD_LSB +: csmx_pkg::SPR_IDX_W]] <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cond_flags_reg <= csmx_pkg::RST_WORD;
		else if (commit)
			cond_flags_reg <= cond_flags_next;
		else if (apb_wr && !pslverr && paddr == csmx_pkg::OFS_COND)
			cond_flags_reg <= pwdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fixed_point_exc_reg <= csmx_pkg::RST_WORD;
		else if (commit && op == csmx_pkg::OPK_MAC && ovf_en) begin
			fixed_point_exc_reg[csmx_pkg::XER_SO] <= so_now;
			fixed_point_exc_reg[csmx_pkg::XER_OV] <= mac_carry;
		end else if (commit && op == csmx_pkg::OPK_EXC_TO_CR)
			fixed_point_exc_reg[csmx_pkg::XER_TOP_LSB +: csmx_pkg::CR_FIELD_W] <= '0;
		else if (apb_wr && !pslverr && paddr == csmx_pkg::OFS_FXEXC)
			fixed_point_exc_reg <= pwdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			machine_state_reg <= csmx_pkg::RST_MSTATE;
			ctrl_reg          <= csmx_pkg::RST_WORD;
			irq_en_reg        <= '0;
		end else if (apb_wr && !pslverr) begin
			if (paddr == csmx_pkg::OFS_MSTATE)
				machine_state_reg <= pwdata;
			if (paddr == csmx_pkg::OFS_CTRL)
				ctrl_reg <= pwdata;
			if (paddr == csmx_pkg::OFS_IRQ_EN)
				irq_en_reg <= pwdata[csmx_pkg::IRQ_W-1:0];
		end
	end

	// Faults and the listed ops never touch each other's outcome
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			issue_ready      <= 1'b0;
			retire_valid     <= 1'b0;
			retire_prog_exc  <= 1'b0;
			retire_unclaimed <= 1'b0;
			retired_reg      <= csmx_pkg::RST_WORD;
		end else begin
			issue_ready      <= ctrl_reg[csmx_pkg::CTRL_EN];
			retire_valid     <= take;
			retire_prog_exc  <= take & fault;
			retire_unclaimed <= take & (op == csmx_pkg::OPK_NONE);
			if (commit)
				retired_reg <= retired_reg + 32'h0000_0001;
		end
	end

	assign irq_set[csmx_pkg::IRQ_RETIRE]  = commit;
	assign irq_set[csmx_pkg::IRQ_PROG]    = take & fault;
	assign irq_set[csmx_pkg::IRQ_OVF]     = commit & (op == csmx_pkg::OPK_MAC) & ovf_en & mac_carry;
	assign irq_set[csmx_pkg::IRQ_UNCLAIM] = take & (op == csmx_pkg::OPK_NONE);

	// A new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= '0;
			irq <= 1'b0;
		end else begin
			if (apb_wr && !pslverr && paddr == csmx_pkg::OFS_IRQ_CLR)
				irq_stat_reg <= (irq_stat_reg & ~pwdata[csmx_pkg::IRQ_W-1:0]) | irq_set;
			else
				irq_stat_reg <= irq_stat_reg | irq_set;
			irq <= |(irq_stat_reg & irq_en_reg);
		end
	end

	// Checks
	logic [31:0] chk_prod;
	logic [32:0] chk_sum;
	// Widened first: a product inside braces would keep only 16 bits
	assign chk_prod = 32'(gpr_mem[ra_idx][csmx_pkg::HALF_W-1:0]) *
		32'(gpr_mem[rb_idx][csmx_pkg::HALF_W-1:0]);
	assign chk_sum  = {1'b0, chk_prod} + {1'b0, gpr_mem[rd_idx]};

	sequence s_take(csmx_pkg::csmx_op_t k);
		take && !fault && op == k;
	endsequence

	property p_mac_decode;
		@(posedge pclk) disable iff (!presetn)
		take && issue_instr[31:26] == csmx_pkg::PO_MAC && issue_instr[9:1] == 9'h18C
			|-> op == csmx_pkg::OPK_MAC;
	endproperty
	a_mac_decode: assert property (p_mac_decode) else $error("mac not decoded");

	property p_mac_result;
		logic [4:0] d;
		logic [32:0] s;
		@(posedge pclk) disable iff (!presetn)
		(s_take(csmx_pkg::OPK_MAC), d = rd_idx, s = chk_sum) |=> gpr_mem[d] == s[31:0];
	endproperty
	a_mac_result: assert property (p_mac_result) else $error("mac result wrong");

	property p_mac_ovf;
		logic [32:0] s;
		@(posedge pclk) disable iff (!presetn)
		(s_take(csmx_pkg::OPK_MAC) ##0 ovf_en, s = chk_sum)
			|=> fixed_point_exc_reg[30] == s[32] && (s[32] -> fixed_point_exc_reg[31]);
	endproperty
	a_mac_ovf: assert property (p_mac_ovf) else $error("overflow flag wrong");

	property p_mac_rec;
		logic [32:0] s;
		@(posedge pclk) disable iff (!presetn)
		(s_take(csmx_pkg::OPK_MAC) ##0 record_flag, s = chk_sum)
			|=> cond_flags_reg[31:29] == {s[31], ~s[31] & (|s[31:0]), ~(|s[31:0])}
				&& cond_flags_reg[28] == fixed_point_exc_reg[31];
	endproperty
	a_mac_rec: assert property (p_mac_rec) else $error("field0 flags wrong");

	property p_copy;
		logic [3:0] v;
		logic [2:0] n;
		@(posedge pclk) disable iff (!presetn)
		(s_take(csmx_pkg::OPK_COPY_CR), v = cond_flags_reg[cr_lsb(src_cond_field) +: 4],
			n = dest_cond_field) |=> cond_flags_reg[cr_lsb(n) +: 4] == v;
	endproperty
	a_copy: assert property (p_copy) else $error("field copy wrong");

	property p_exc_move;
		logic [3:0] v;
		logic [2:0] n;
		@(posedge pclk) disable iff (!presetn)
		(s_take(csmx_pkg::OPK_EXC_TO_CR), v = fixed_point_exc_reg[31:28], n = dest_cond_field)
			|=> cond_flags_reg[cr_lsb(n) +: 4] == v && fixed_point_exc_reg[31:28] == 4'h0;
	endproperty
	a_exc_move: assert property (p_exc_move) else $error("exception move wrong");

	property p_priv;
		@(posedge pclk) disable iff (!presetn)
		take && user_mode && (op == csmx_pkg::OPK_RD_DCR || op == csmx_pkg::OPK_RD_MSR)
			|=> retire_valid && retire_prog_exc;
	endproperty
	a_priv: assert property (p_priv) else $error("privilege fault missing");

	property p_spr_priv;
		@(posedge pclk) disable iff (!presetn)
		take && op == csmx_pkg::OPK_RD_SPR && user_mode
			|=> retire_valid && retire_prog_exc == $past(issue_instr[20]);
	endproperty
	a_spr_priv: assert property (p_spr_priv) else $error("special privilege wrong");

	property p_rd_msr;
		logic [4:0] d;
		logic [31:0] v;
		@(posedge pclk) disable iff (!presetn)
		(s_take(csmx_pkg::OPK_RD_MSR), d = rd_idx, v = machine_state_reg) |=> gpr_mem[d] == v;
	endproperty
	a_rd_msr: assert property (p_rd_msr) else $error("state read wrong");

	property p_no_exc;
		@(posedge pclk) disable iff (!presetn)
		take && (op == csmx_pkg::OPK_MAC || op == csmx_pkg::OPK_COPY_CR ||
			op == csmx_pkg::OPK_EXC_TO_CR || op == csmx_pkg::OPK_RD_CR) |=> !retire_prog_exc;
	endproperty
	a_no_exc: assert property (p_no_exc) else $error("unexpected exception");
endmodule

// ---- tb/csmx_fetch.sv ----
/*
 Fetch stage model: offers one instruction word per request.
 Assumes the core takes a word on an edge where issue_ready is high.
*/
`timescale 1ns/1ps
module csmx_fetch (
	input  wire logic        pclk,
	input  wire logic        req,
	input  wire logic [31:0] req_instr,
	input  wire logic        issue_ready,
	output logic             issue_valid,
	output logic      [31:0] issue_instr
);
	initial issue_valid = 1'b0;
	initial issue_instr = 32'h0000_0000;
	// Word inverted once taken, so a stale copy is never mistaken for a new one
	always @(posedge pclk) begin
		if (issue_valid && issue_ready) begin
			issue_valid <= 1'b0;
			issue_instr <= ~issue_instr;
		end else if (req && !issue_valid) begin
			issue_valid <= 1'b1;
			issue_instr <= req_instr;
		end
	end
endmodule

// ---- tb/cond_special_move_mac_exec_bench.sv ----
/*
 Bench for the execute core: APB master, fetch model and scenarios.
 Assumes one APB wait state and retirement one cycle after issue.
*/
`timescale 1ns/1ps
module cond_special_move_mac_exec_bench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        issue_valid;
	logic [31:0] issue_instr;
	logic        issue_ready;
	logic        retire_valid;
	logic        retire_prog_exc;
	logic        retire_unclaimed;
	logic        irq;
	logic        req = 1'b0;
	logic [31:0] req_instr = 32'h0000_0000;
	logic [31:0] r_v;
	logic        e_v;
	int          fail_count = 0;
	int          check_count = 0;
	int          cyc = 0;
	always #12.5 pclk = ~pclk;
	csmx_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .issue_valid, .issue_instr, .issue_ready, .retire_valid,
		.retire_prog_exc, .retire_unclaimed, .irq);
	csmx_fetch u_fetch (.pclk, .req, .req_instr, .issue_ready, .issue_valid, .issue_instr);
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		// Whole run needs a few hundred cycles
		if (cyc == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait limit here: only the bench timeout ends a hung access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r_v = prdata;
		e_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk("register", r_v, exp);
	endtask
	task automatic exr(input logic [31:0] ins, input logic [2:0] exp_r);
		int n;
		req_instr <= ins;
		req <= 1'b1;
		@(posedge pclk);
		req <= 1'b0;
		n = 0;
		while (retire_valid !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		chk("retire", {29'h0, retire_valid, retire_unclaimed, retire_prog_exc},
			{29'h0, exp_r});
	endtask
	task automatic ex(input logic [31:0] ins, input logic exc);
		exr(ins, {2'b10, exc});
	endtask
	function automatic logic [31:0] mac(logic oe, logic rc1, logic [4:0] d);
		return {6'h04, d, 5'h01, 5'h02, oe, 9'h18C, rc1};
	endfunction
	function automatic logic [31:0] x31(logic [4:0] d, logic [9:0] f, logic [9:0] xo);
		return {6'h1F, d, f, xo, 1'b0};
	endfunction
	task automatic t_setup();
		rc(12'h004, 32'h0000_0000);
		rc(12'h008, 32'h0000_0000);
		apb(1'b0, 12'h040, 32'h0000_0000);
		chk("unmapped", {31'h0, e_v}, 32'h0000_0001);
		wr(12'h000, 32'h0000_0001);
		wr(12'h014, 32'h0000_0002);
		$display("setup test done");
	endtask
	task automatic t_mac();
		wr(12'h104, 32'h1234_FFFF);
		wr(12'h108, 32'hABCD_FFFF);
		wr(12'h10C, 32'h0002_0000);
		wr(12'h110, 32'h0002_0000);
		ex(mac(1'b0, 1'b0, 5'd3), 1'b0);
		rc(12'h10C, 32'h0000_0001);
		rc(12'h004, 32'h0000_0000);
		ex(mac(1'b1, 1'b1, 5'd4), 1'b0);
		rc(12'h110, 32'h0000_0001);
		rc(12'h004, 32'h5000_0000);
		rc(12'h008, 32'hC000_0000);
		$display("multiply-accumulate test done");
	endtask
	task automatic t_cond();
		ex(x31(5'h1C, 10'h000, 10'd512), 1'b0);
		rc(12'h004, 32'h5000_000C);
		rc(12'h008, 32'h0000_0000);
		ex({6'h13, 5'h08, 5'h00, 16'h0000}, 1'b0);
		rc(12'h004, 32'h5050_000C);
		ex(x31(5'd5, 10'h3FF, 10'd19), 1'b0);
		rc(12'h114, 32'h5050_000C);
		$display("condition field test done");
	endtask
	task automatic t_priv();
		wr(12'h208, 32'h0000_A5A5);
		wr(12'h314, 32'h0000_5A5A);
		wr(12'h00C, 32'h0000_0100);
		ex(x31(5'd6, 10'h040, 10'd323), 1'b0);
		rc(12'h118, 32'h0000_A5A5);
		ex(x31(5'd7, 10'h0A0, 10'd339), 1'b0);
		rc(12'h11C, 32'h0000_5A5A);
		ex(x31(5'd9, 10'h000, 10'd83), 1'b0);
		rc(12'h124, 32'h0000_0100);
		ex(x31(5'd9, 10'h3E0, 10'd323), 1'b0);
		rc(12'h124, 32'h0000_0000);
		wr(12'h124, 32'h0000_FFFF);
		ex(x31(5'd9, 10'h200, 10'd339), 1'b0);
		rc(12'h124, 32'h0000_0000);
		// Register file has no reset; seed the faulting target
		wr(12'h120, 32'h0000_0000);
		wr(12'h00C, 32'h0000_4000);
		ex(x31(5'd8, 10'h000, 10'd83), 1'b1);
		ex(x31(5'd8, 10'h040, 10'd323), 1'b1);
		ex(x31(5'd8, 10'h200, 10'd339), 1'b1);
		rc(12'h120, 32'h0000_0000);
		ex(x31(5'd8, 10'h0A0, 10'd339), 1'b0);
		rc(12'h120, 32'h0000_5A5A);
		chk("irq", {31'h0, irq}, 32'h0000_0001);
		wr(12'h018, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		chk("irq", {31'h0, irq}, 32'h0000_0000);
		$display("privilege test done");
	endtask
	task automatic t_unclaimed();
		exr(32'h0000_0000, 3'b110);
		rc(12'h004, 32'h5050_000C);
		$display("unclaimed opcode test done");
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_setup();
		t_mac();
		t_cond();
		t_priv();
		t_unclaimed();
		report_and_stop();
	end
endmodule
